// ---- hdl/mib_issue_ctrl.sv ----
/*
  mib_issue_ctrl: issue stalls for library call and barriers, prefetch hand-off, sequence flag.
  assumes: decoder holds in_valid/in_op until issue_ready; pipeline status inputs are on sys_clk.
*/
//
// What this block does
// RL1 - library call waits until no older exception possible
// RL2 - exception while call pending saves call address
// RL3 - call traps into library code, raises nothing
// RL4 - prefetch names aligned 512-byte block of base
// RL5 - prefetch may be dropped; fetch order unspecified
// RL6 - modify-intent variant may request writable block
// RL7 - faulting prefetch silently discarded, never excepts
// RL8 - prefetch takes translation miss, then continues
// RL9 - barrier: later accesses wait for earlier ones
// RL10 - without barrier, accesses may complete any order
// RL11 - barrier only orders, never forces completion
// RL12 - trap barrier stalls until no arithmetic trap
// RL13 - software uses trap barrier before handler switch
// RL14 - read flag to destination, then clear/set it
// RL15 - per-processor flag cleared by exception return
// RL16 - loads, stores, branches keep the flag
`timescale 1ns/1ps
module mib_issue_ctrl
  import mib_pkg::*;
#(
  parameter bit PF_ENABLE = 1'b1  // zero turns prefetch hints into no-operations
)(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire mib_op_t in_op,
  input wire logic [VA_W-1:0] in_pc,
  input wire logic [VA_W-1:0] in_base_addr,
  input wire logic [PAL_FN_W-1:0] in_pal_func,
  input wire logic in_pal_eret,
  output logic issue_ready,
  input wire logic older_may_except,
  input wire logic older_may_arith_trap,
  input wire logic mem_outstanding,
  input wire logic exc_taken,
  output logic cont_pc_valid,
  output logic [VA_W-1:0] cont_pc,
  output logic pal_trap_valid,
  output logic [PAL_FN_W-1:0] pal_trap_func,
  output logic result_valid,
  output logic result_data,
  output logic seq_flag,
  output logic xlat_req,
  output logic [VA_W-1:0] xlat_addr,
  input wire logic xlat_done,
  input wire logic xlat_load_fault,
  input wire logic xlat_store_fault,
  input wire logic xlat_tb_miss,
  output logic tb_miss_fault,
  output logic mem_valid,
  output logic [BLK_W-1:0] mem_block,
  output logic mem_modify,
  input wire logic mem_ready
);
  typedef enum logic [1:0] {ST_IDLE, ST_PAL_WAIT, ST_TRAP_WAIT, ST_MB_WAIT} mib_st_t;

  mib_pf_if pf_bus ();                      // hint path to the prefetch engine

  mib_st_t st_ff, nxt_st;                   // issue state
  logic [VA_W-1:0] pc_ff, nxt_pc;           // address of the pending library call
  logic [PAL_FN_W-1:0] fn_ff, nxt_fn;       // its function code
  logic eret_ff, nxt_eret;                  // pending call is exception return
  logic cpv_ff, nxt_cpv;                    // continuation address pulse
  logic [VA_W-1:0] cpc_ff, nxt_cpc;         // continuation address
  logic trap_ff, nxt_trap;                  // library entry pulse
  logic [PAL_FN_W-1:0] tfn_ff, nxt_tfn;     // library entry function
  logic flag_ff, nxt_flag;                  // uninterrupted-sequence flag
  logic rv_ff, nxt_rv;                      // flag read result pulse
  logic rd_ff, nxt_rd;                      // flag read result value
  logic take;                               // instruction issued this cycle
  logic is_fetch;                           // offered op is a prefetch hint

  assign is_fetch = (in_op == OP_FETCH) || (in_op == OP_FETCH_M);
  // wait states block all later issue; hints also wait for engine room
  assign issue_ready = (st_ff == ST_IDLE) && !(is_fetch && !pf_bus.req_ready); // [RL1] [RL12]
  assign take = in_valid && issue_ready;

  // hint forwarded as issued; a fault on it is never reported, only a translation miss is [RL7]
  assign pf_bus.req_valid = in_valid && (st_ff == ST_IDLE) && is_fetch;
  assign pf_bus.req_addr = in_base_addr; // [RL4]
  assign pf_bus.req_modify = (in_op == OP_FETCH_M); // [RL6]

  // issue and barrier sequencing
  always_comb
  begin
    nxt_st = st_ff;
    nxt_pc = pc_ff;
    nxt_fn = fn_ff;
    nxt_eret = eret_ff;
    nxt_cpv = 1'b0;
    nxt_cpc = cpc_ff;
    nxt_trap = 1'b0;
    nxt_tfn = tfn_ff;
    unique case (st_ff)
      ST_IDLE:
      begin
        if (take)
        begin
          unique case (in_op)
            OP_PAL_CALL:
            begin
              nxt_pc = in_pc;
              nxt_fn = in_pal_func;
              nxt_eret = in_pal_eret;
              nxt_st = ST_PAL_WAIT;
            end
            OP_TRAP_BARRIER: nxt_st = ST_TRAP_WAIT;
            // only this processor's order; nothing is pushed out [RL9] [RL11]
            OP_MEM_BARRIER: nxt_st = ST_MB_WAIT;
            // loads and stores otherwise flow without ordering here [RL10]
            default: nxt_st = ST_IDLE;
          endcase
        end
      end
      ST_PAL_WAIT:
      begin
        if (exc_taken)
        begin
          // resume at the call itself, which then reissues [RL2]
          nxt_cpv = 1'b1;
          nxt_cpc = pc_ff;
          nxt_st = ST_IDLE;
        end
        else if (!older_may_except) // [RL1]
        begin
          nxt_trap = 1'b1; // enter library code [RL3]
          nxt_tfn = fn_ff;
          nxt_st = ST_IDLE;
        end
      end
      ST_TRAP_WAIT:
      begin
        // older traps still reach the current handler [RL13]
        if (exc_taken || !older_may_arith_trap) // [RL12]
          nxt_st = ST_IDLE;
      end
      ST_MB_WAIT:
      begin
        // wait for drain, which the memory system does at its own pace [RL11]
        if (exc_taken || !mem_outstanding) // [RL9]
          nxt_st = ST_IDLE;
      end
    endcase
  end

  // issue state registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= ST_IDLE;
      pc_ff <= '0;
      fn_ff <= '0;
      eret_ff <= 1'b0;
      cpv_ff <= 1'b0;
      cpc_ff <= '0;
      trap_ff <= 1'b0;
      tfn_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      pc_ff <= nxt_pc;
      fn_ff <= nxt_fn;
      eret_ff <= nxt_eret;
      cpv_ff <= nxt_cpv;
      cpc_ff <= nxt_cpc;
      trap_ff <= nxt_trap;
      tfn_ff <= nxt_tfn;
    end
  end

  // sequence flag; exception return and flag ops cannot coincide
  always_comb
  begin
    nxt_flag = flag_ff;
    nxt_rv = 1'b0;
    nxt_rd = rd_ff;
    if (nxt_trap && eret_ff)
      nxt_flag = FLAG_CLR; // [RL15]
    else if (take && (in_op == OP_READ_CLEAR || in_op == OP_READ_SET))
    begin
      nxt_rv = 1'b1;
      nxt_rd = flag_ff; // old value to destination [RL14]
      nxt_flag = (in_op == OP_READ_SET) ? FLAG_SET : FLAG_CLR; // [RL14]
    end
    // locked pairs, loads, stores, branches leave it alone [RL16]
  end

  // one flag per processor instance
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flag_ff <= FLAG_RST; // [RL15]
      rv_ff <= 1'b0;
      rd_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
    end
  end

  assign cont_pc_valid = cpv_ff;
  assign cont_pc = cpc_ff;
  assign pal_trap_valid = trap_ff;
  assign pal_trap_func = tfn_ff;
  assign result_valid = rv_ff;
  assign result_data = rd_ff;
  assign seq_flag = flag_ff;

  // prefetch engine: fault filtering and block request
  mib_prefetch #(
    .PF_ENABLE(PF_ENABLE)
  ) u_pf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pf(pf_bus.dst),
    .xlat_req(xlat_req),
    .xlat_addr(xlat_addr),
    .xlat_done(xlat_done),
    .xlat_load_fault(xlat_load_fault),
    .xlat_store_fault(xlat_store_fault),
    .xlat_tb_miss(xlat_tb_miss),
    .tb_miss_fault(tb_miss_fault),
    .mem_valid(mem_valid),
    .mem_block(mem_block),
    .mem_modify(mem_modify),
    .mem_ready(mem_ready)
  );

  sequence s_pal_pending;
    st_ff == ST_PAL_WAIT && !exc_taken;
  endsequence
  pal_stall_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL1]
    s_pal_pending ##0 older_may_except |=> !pal_trap_valid && !issue_ready)
    else $error("library call entered with older exception possible");
  pal_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL3]
    s_pal_pending ##0 !older_may_except |=> pal_trap_valid && pal_trap_func == $past(fn_ff) && !cont_pc_valid)
    else $error("library call did not enter library code");
  pal_cont_pc_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL2]
    (st_ff == ST_PAL_WAIT && exc_taken) |=> cont_pc_valid && cont_pc == $past(pc_ff) && !pal_trap_valid)
    else $error("continuation address not the library call");
  trap_stall_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL12]
    (st_ff == ST_TRAP_WAIT && older_may_arith_trap && !exc_taken) |=> !issue_ready)
    else $error("issue past trap barrier with trap possible");
  mb_order_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL9]
    (st_ff == ST_MB_WAIT && mem_outstanding && !exc_taken) |=> !issue_ready)
    else $error("issue past memory barrier before drain");
  rc_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL14]
    (take && in_op == OP_READ_CLEAR) |=> result_valid && result_data == $past(flag_ff) && seq_flag == FLAG_CLR)
    else $error("read-and-clear result or flag wrong");
  rs_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL14]
    (take && in_op == OP_READ_SET) |=> result_valid && result_data == $past(flag_ff) && seq_flag == FLAG_SET)
    else $error("read-and-set result or flag wrong");
  eret_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL15]
    (pal_trap_valid && $past(eret_ff)) |-> seq_flag == FLAG_CLR)
    else $error("exception return left the flag set");
  flag_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL16]
    (take && (in_op == OP_OTHER || in_op == OP_LOAD_LOCKED || in_op == OP_STORE_COND)) |=> $stable(seq_flag))
    else $error("flag changed by unrelated instruction");
endmodule

// ---- hdl/mib_pf_if.sv ----
/*
  mib_pf_if: prefetch hand-off between the issue control and the prefetch engine.
  assumes: both ends on sys_clk; a request moves when req_valid and req_ready are both high.
*/
`timescale 1ns/1ps
interface mib_pf_if;
  import mib_pkg::*;
  logic req_valid;              // prefetch hint offered
  logic req_ready;              // engine can take a hint
  logic [VA_W-1:0] req_addr;    // base register value
  logic req_modify;             // modify-intent variant

  modport src (output req_valid, output req_addr, output req_modify, input req_ready);
  modport dst (input req_valid, input req_addr, input req_modify, output req_ready);
endinterface

// ---- hdl/mib_pkg.sv ----
/*
  mib_pkg: shared types and constants for the miscellaneous issue and barrier control.
  assumes: single clock domain, decoder supplies an already classified opcode.
*/
package mib_pkg;
  // address and block geometry
  localparam int VA_W = 64;                 // virtual address width
  localparam int BLK_BYTES = 512;           // prefetch block size in bytes
  localparam int BLK_LSB = $clog2(BLK_BYTES); // offset bits inside a block
  localparam int BLK_W = VA_W - BLK_LSB;    // width of a block number
  localparam int PAL_FN_W = 26;             // library call function field width
  // uninterrupted-sequence flag values
  localparam logic FLAG_CLR = 1'h0;         // value after read-and-clear
  localparam logic FLAG_SET = 1'h1;         // value after read-and-set
  localparam logic FLAG_RST = 1'h0;         // value after reset

  // classified instruction handed over by the decoder
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_PAL_CALL,
    OP_FETCH,
    OP_FETCH_M,
    OP_MEM_BARRIER,
    OP_TRAP_BARRIER,
    OP_READ_CLEAR,
    OP_READ_SET,
    OP_LOAD_LOCKED,
    OP_STORE_COND
  } mib_op_t;
endpackage

// ---- hdl/mib_prefetch.sv ----
/*
  mib_prefetch: turns a prefetch hint into a block request to the memory system.
  assumes: translation unit answers xlat_req with one xlat_done pulse; memory takes mem_valid&&mem_ready.
*/
`timescale 1ns/1ps
module mib_prefetch
  import mib_pkg::*;
#(
  parameter bit PF_ENABLE = 1'b1  // zero makes every hint a no-operation
)(
  input wire logic sys_clk,
  input wire logic sys_rst,
  mib_pf_if.dst pf,
  output logic xlat_req,
  output logic [VA_W-1:0] xlat_addr,
  input wire logic xlat_done,
  input wire logic xlat_load_fault,
  input wire logic xlat_store_fault,
  input wire logic xlat_tb_miss,
  output logic tb_miss_fault,
  output logic mem_valid,
  output logic [BLK_W-1:0] mem_block,
  output logic mem_modify,
  input wire logic mem_ready
);
  typedef enum logic [1:0] {PF_IDLE, PF_XLAT, PF_SEND} mib_pf_st_t;

  mib_pf_st_t st_ff, nxt_st;          // engine state
  logic [VA_W-1:0] addr_ff, nxt_addr; // captured hint address
  logic mod_ff, nxt_mod;              // captured modify intent
  logic tbm_ff, nxt_tbm;              // translation-miss fault pulse

  // next state: idle takes hints, xlat checks, send offers block
  always_comb
  begin
    nxt_st = st_ff;
    nxt_addr = addr_ff;
    nxt_mod = mod_ff;
    nxt_tbm = 1'b0;
    unique case (st_ff)
      PF_IDLE:
      begin
        // hints are accepted even when disabled, then dropped
        if (pf.req_valid && PF_ENABLE) // [RL5]
        begin
          nxt_addr = pf.req_addr; // [RL4]
          nxt_mod = pf.req_modify; // [RL6]
          nxt_st = PF_XLAT;
        end
      end
      PF_XLAT:
      begin
        if (xlat_done)
        begin
          if (xlat_tb_miss)
            nxt_tbm = 1'b1; // take the miss, retry after refill [RL8]
          else if (xlat_load_fault || (mod_ff && xlat_store_fault))
            nxt_st = PF_IDLE; // faulting hint silently dropped [RL7]
          else
            nxt_st = PF_SEND;
        end
      end
      PF_SEND:
      begin
        if (mem_ready)
          nxt_st = PF_IDLE;
      end
      // unused state code falls back to idle rather than locking up
      default: nxt_st = PF_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= PF_IDLE;
      addr_ff <= '0;
      mod_ff <= 1'b0;
      tbm_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      addr_ff <= nxt_addr;
      mod_ff <= nxt_mod;
      tbm_ff <= nxt_tbm;
    end
  end

  assign pf.req_ready = (st_ff == PF_IDLE);
  // a miss pulse drops the request for one cycle so translation restarts
  assign xlat_req = (st_ff == PF_XLAT) && !tbm_ff;
  assign xlat_addr = addr_ff;
  assign tb_miss_fault = tbm_ff;
  assign mem_valid = (st_ff == PF_SEND);
  // whole aligned block; order inside it is left to memory [RL4] [RL5]
  assign mem_block = addr_ff[VA_W-1:BLK_LSB];
  assign mem_modify = mod_ff; // [RL6]

  pf_fault_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL7]
    (st_ff == PF_XLAT && xlat_done && !xlat_tb_miss && xlat_load_fault) |=> !mem_valid [*2])
    else $error("faulting prefetch reached memory");
  pf_tbmiss_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL8]
    (st_ff == PF_XLAT && xlat_done && xlat_tb_miss) |=> tb_miss_fault ##1 xlat_req)
    else $error("translation miss not taken and retried");
endmodule

// ---- verification/mib_far_model.sv ----
/*
  mib_far_model: translation unit and memory system seen by the prefetch engine.
  assumes: sys_clk domain; tb picks fault mix and answer latency per hint.
*/
`timescale 1ns/1ps
module mib_far_model
  import mib_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic xlat_req,
  input wire logic mem_valid,
  input wire logic [2:0] cfg,
  input wire logic [3:0] lat,
  output logic xlat_done,
  output logic xlat_load_fault,
  output logic xlat_store_fault,
  output logic xlat_tb_miss,
  output logic mem_ready
);
  logic [3:0] cnt_ff; // cycles waited on the current request
  logic tog_ff; // junk pattern for fault lines outside a done pulse
  logic seen_ff; // miss already reported, retry translates cleanly

  // answer translation and memory after lat+1 cycles, one pulse each
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_ff <= 4'h0;
      tog_ff <= 1'h0;
      seen_ff <= 1'h0;
      xlat_done <= 1'h0;
      mem_ready <= 1'h0;
    end
    else
    begin
      tog_ff <= ~tog_ff;
      xlat_done <= 1'h0;
      mem_ready <= 1'h0;
      if ((xlat_req && !xlat_done) || (mem_valid && !mem_ready))
      begin
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff >= lat)
        begin
          cnt_ff <= 4'h0;
          xlat_done <= xlat_req;
          mem_ready <= mem_valid;
        end
      end
      if (xlat_done && xlat_tb_miss)
        seen_ff <= 1'h1;
      if (mem_valid && mem_ready)
        seen_ff <= 1'h0;
    end
  end

  // fault levels only mean something with done; otherwise they wander
  assign xlat_load_fault = xlat_done ? cfg[2] : tog_ff;
  assign xlat_store_fault = xlat_done ? cfg[1] : ~tog_ff;
  assign xlat_tb_miss = xlat_done ? (cfg[0] & ~seen_ff) : tog_ff;
endmodule

// ---- verification/testbench.sv ----
/*
  testbench: issue stalls, sequence flag and prefetch hand-off of mib_issue_ctrl.
  assumes: mib_far_model stands in for translation and memory; tb plays decoder.
*/
`timescale 1ns/1ps
module testbench;
  import mib_pkg::*;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t got %h expected %h", $time, g, e); end end

  // row: op, eret, base, fault mix, {nres, res, flag, nmem, nmiss}
  typedef struct packed {mib_op_t op; logic eret; logic [VA_W-1:0] a; logic [2:0] cfg; logic [4:0] e;} mib_row_t;
  localparam logic [VA_W-1:0] PA = 64'h0123_4567_89ab_cdef;
  localparam logic [VA_W-1:0] PB = 64'hffff_ffff_ffff_fe00;
  mib_row_t rows [20] = '{
    '{OP_READ_SET, 1'h0, '0, 3'h0, 5'h14}, '{OP_READ_SET, 1'h0, '0, 3'h0, 5'h1c},
    '{OP_OTHER, 1'h0, '0, 3'h0, 5'h04}, '{OP_LOAD_LOCKED, 1'h0, '0, 3'h0, 5'h04},
    '{OP_STORE_COND, 1'h0, '0, 3'h0, 5'h04}, '{OP_READ_CLEAR, 1'h0, '0, 3'h0, 5'h18},
    '{OP_READ_CLEAR, 1'h0, '0, 3'h0, 5'h10}, '{OP_READ_SET, 1'h0, '0, 3'h0, 5'h14},
    '{OP_PAL_CALL, 1'h1, PA, 3'h0, 5'h00}, '{OP_READ_SET, 1'h0, '0, 3'h0, 5'h14},
    '{OP_PAL_CALL, 1'h0, PB, 3'h0, 5'h04}, '{OP_FETCH, 1'h0, PA, 3'h0, 5'h06},
    '{OP_FETCH_M, 1'h0, PB, 3'h0, 5'h06}, '{OP_FETCH, 1'h0, PA, 3'h4, 5'h04},
    '{OP_FETCH_M, 1'h0, PB, 3'h2, 5'h04}, '{OP_FETCH, 1'h0, PB, 3'h2, 5'h06},
    '{OP_FETCH_M, 1'h0, PA, 3'h1, 5'h07}, '{OP_FETCH_M, 1'h0, PA, 3'h4, 5'h04},
    '{OP_MEM_BARRIER, 1'h0, '0, 3'h0, 5'h04}, '{OP_TRAP_BARRIER, 1'h0, '0, 3'h0, 5'h04}};

  logic sys_clk, sys_rst, in_valid, in_pal_eret, issue_ready;
  mib_op_t in_op;
  logic [VA_W-1:0] in_pc, in_base_addr, cont_pc, xlat_addr, got_xa;
  logic [PAL_FN_W-1:0] in_pal_func, pal_trap_func, got_fn;
  logic older_may_except, older_may_arith_trap, mem_outstanding, exc_taken;
  logic cont_pc_valid, pal_trap_valid, result_valid, result_data, seq_flag, xlat_req;
  logic xlat_done, xlat_load_fault, xlat_store_fault, xlat_tb_miss, tb_miss_fault;
  logic mem_valid, mem_modify, mem_ready, got_res, got_mod;
  logic [BLK_W-1:0] mem_block, got_blk;
  logic [2:0] cfg;
  logic [3:0] lat;
  int err_total, checks_done, n_res, n_pal, n_mem, n_miss;

  mib_issue_ctrl i_mib_issue_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .in_valid(in_valid), .in_op(in_op),
    .in_pc(in_pc), .in_base_addr(in_base_addr), .in_pal_func(in_pal_func), .in_pal_eret(in_pal_eret),
    .issue_ready(issue_ready), .older_may_except(older_may_except), .older_may_arith_trap(older_may_arith_trap),
    .mem_outstanding(mem_outstanding), .exc_taken(exc_taken), .cont_pc_valid(cont_pc_valid), .cont_pc(cont_pc),
    .pal_trap_valid(pal_trap_valid), .pal_trap_func(pal_trap_func), .result_valid(result_valid),
    .result_data(result_data), .seq_flag(seq_flag), .xlat_req(xlat_req), .xlat_addr(xlat_addr),
    .xlat_done(xlat_done), .xlat_load_fault(xlat_load_fault), .xlat_store_fault(xlat_store_fault),
    .xlat_tb_miss(xlat_tb_miss), .tb_miss_fault(tb_miss_fault), .mem_valid(mem_valid), .mem_block(mem_block),
    .mem_modify(mem_modify), .mem_ready(mem_ready));
  mib_far_model i_mib_far_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .xlat_req(xlat_req),
    .mem_valid(mem_valid), .cfg(cfg), .lat(lat), .xlat_done(xlat_done), .xlat_load_fault(xlat_load_fault),
    .xlat_store_fault(xlat_store_fault), .xlat_tb_miss(xlat_tb_miss), .mem_ready(mem_ready));

  // clock, 10 ns period
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // pulse monitor, reads values that stood during the closing cycle
  always @(posedge sys_clk)
  begin
    if (result_valid === 1'h1)
    begin
      n_res++;
      got_res = result_data;
    end
    if (pal_trap_valid === 1'h1)
    begin
      n_pal++;
      got_fn = pal_trap_func;
    end
    if (tb_miss_fault === 1'h1)
      n_miss++;
    // last address offered for translation
    if (xlat_req === 1'h1)
      got_xa = xlat_addr;
    if (mem_valid === 1'h1 && mem_ready === 1'h1)
    begin
      n_mem++;
      got_blk = mem_block;
      got_mod = mem_modify;
    end
  end

  task automatic results();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // offer one op until taken; hold keeps in_valid up for back-to-back
  task automatic issue(input mib_op_t op, input logic [VA_W-1:0] a, input logic eret, input logic hold);
    logic r;
    int n;
    n = 0;
    in_valid = 1'h1;
    in_op = op;
    in_base_addr = a;
    in_pc = ~a;
    in_pal_func = a[PAL_FN_W-1:0];
    in_pal_eret = eret;
    do
    begin
      #8 r = issue_ready;
      @(posedge sys_clk);
      #1 n++;
    end
    while (r !== 1'h1 && n < 100);
    // an offer that is never taken counts against the run
    if (r !== 1'h1)
      err_total++;
    if (!hold)
      in_valid = 1'h0;
  endtask

  // barrier holds issue while its status is up, frees one edge after it drops
  task automatic stall_chk(input mib_op_t op);
    issue(op, '0, 1'h0, 1'h0);
    repeat (3)
    begin
      #8 `CHK(issue_ready, 1'h0)
      @(posedge sys_clk);
      #1;
    end
    mem_outstanding = 1'h0;
    older_may_arith_trap = 1'h0;
    #8 `CHK(issue_ready, 1'h0)
    @(posedge sys_clk);
    #9 `CHK(issue_ready, 1'h1)
    @(posedge sys_clk);
    #1;
  endtask

  initial
  begin
    {sys_rst, in_valid, in_pal_eret, older_may_except, older_may_arith_trap} = 5'h10;
    {mem_outstanding, exc_taken, cfg, lat} = 9'h000;
    in_op = OP_OTHER;
    {in_pc, in_base_addr, in_pal_func} = '0;
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 1'h0;
    // reset state
    `CHK(issue_ready, 1'h1)
    `CHK(seq_flag, FLAG_RST)
    `CHK({mem_valid, xlat_req}, 2'h0)
    for (int i = 0; i < 20; i++)
    begin
      cfg = rows[i].cfg;
      lat = 4'(i % 5);
      {n_res, n_pal, n_mem, n_miss} = '0;
      got_xa = '0;
      issue(rows[i].op, rows[i].a, rows[i].eret, 1'h0);
      repeat (16) @(posedge sys_clk);
      #1 `CHK(n_res, int'(rows[i].e[4]))
      if (n_res > 0) `CHK(got_res, rows[i].e[3])
      `CHK(seq_flag, rows[i].e[2])
      `CHK(n_pal, int'(rows[i].op == OP_PAL_CALL))
      if (n_pal > 0) `CHK(got_fn, rows[i].a[PAL_FN_W-1:0])
      `CHK(n_mem, int'(rows[i].e[1]))
      if (n_mem > 0) `CHK(got_blk, rows[i].a[VA_W-1:BLK_LSB])
      if (n_mem > 0) `CHK(got_mod, rows[i].op == OP_FETCH_M)
      `CHK(n_miss, int'(rows[i].e[0]))
      if (rows[i].op inside {OP_FETCH, OP_FETCH_M}) `CHK(got_xa, rows[i].a)
    end
    // back-to-back flag ops, result one cycle after each take
    issue(OP_READ_CLEAR, '0, 1'h0, 1'h1);
    `CHK({result_valid, result_data, seq_flag}, 3'h6)
    // valid stays up straight into the library call below
    issue(OP_READ_SET, '0, 1'h0, 1'h1);
    `CHK({result_valid, result_data, seq_flag}, 3'h5)
    // library call held back while an older exception is possible
    older_may_except = 1'h1;
    issue(OP_PAL_CALL, PB, 1'h0, 1'h0);
    repeat (4)
    begin
      #8 `CHK(pal_trap_valid, 1'h0)
      @(posedge sys_clk);
      #1;
    end
    older_may_except = 1'h0;
    @(posedge sys_clk);
    #1 `CHK(pal_trap_valid, 1'h1)
    // exception while a call waits keeps the call address
    older_may_except = 1'h1;
    issue(OP_PAL_CALL, PA, 1'h0, 1'h0);
    exc_taken = 1'h1;
    @(posedge sys_clk);
    #1 exc_taken = 1'h0;
    older_may_except = 1'h0;
    `CHK(cont_pc_valid, 1'h1)
    `CHK(cont_pc, ~PA)
    `CHK(pal_trap_valid, 1'h0)
    mem_outstanding = 1'h1;
    stall_chk(OP_MEM_BARRIER);
    // software side drains traps before a handler change
    older_may_arith_trap = 1'h1;
    stall_chk(OP_TRAP_BARRIER);
    // reset in mid-run with the flag set brings it back to its reset value
    sys_rst = 1'h1;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'h0;
    `CHK(seq_flag, FLAG_RST)
    `CHK({issue_ready, mem_valid, xlat_req}, 3'h4)
    issue(OP_READ_SET, '0, 1'h0, 1'h0);
    `CHK({result_valid, result_data, seq_flag}, 3'h5)
    results();
  end

  // hang guard, the run needs a few microseconds
  initial
  begin
    #20_000;
    err_total++;
    results();
  end
endmodule
